// ===== hdl/plc_cfg.svh
// Offsets, field positions, reset values and counts of the link register block
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH
// Byte address of the combined link control / link status register
`define PLC_LINK_OFS 12'h0d0
// Control field positions (low half)
`define PLC_ACTIVE_STATE_POWER_ENTRY_LSB 0
`define PLC_RCB_BIT 3
`define PLC_DIS_BIT 4
`define PLC_RETRAIN_BIT 5
`define PLC_CCLK_BIT 6
`define PLC_ESYNC_BIT 7
`define PLC_LCCB_BIT 9
`define PLC_BWM_IE_BIT 10
`define PLC_ABW_IE_BIT 11
// Status field positions (high half)
`define PLC_SPEED_LSB 16
`define PLC_WIDTH_LSB 20
`define PLC_TERR_BIT 26
`define PLC_TRAIN_BIT 27
`define PLC_SCLK_BIT 28
`define PLC_DLA_BIT 29
// Reset values
`define PLC_SPEED_RST 4'h2
`define PLC_WIDTH_RST 6'h01
// Ordered-set counts with extended synchronization
`define PLC_ESYNC_FTS 13'h1000
`define PLC_ESYNC_TS1 13'h0400
// Cycles the strap synchroniser needs before its value is trusted
`define PLC_STRAP_WAIT 2'h3
// Bus answers
`define PLC_RESP_OKAY 2'h0
`define PLC_RESP_SLVERR 2'h2
`endif

// ===== hdl/plc_pkg.sv
// Types shared by the link register block
package plc_pkg;
    // Power-state entry control encodings
    typedef enum logic [1:0] {
        PLC_ACTIVE_STATE_POWER_ENTRY_NONE = 2'h0,
        PLC_ACTIVE_STATE_POWER_ENTRY_L0S = 2'h1,
        PLC_ACTIVE_STATE_POWER_ENTRY_L1 = 2'h2,
        PLC_ACTIVE_STATE_POWER_ENTRY_BOTH = 2'h3
    } plc_active_state_power_entry_type;
    // Write channel progress, one-hot
    typedef enum logic [2:0] {
        PLC_WR_IDLE = 3'h1,
        PLC_WR_RESP = 3'h2,
        PLC_WR_DONE = 3'h4
    } plc_wr_state_type;
endpackage

// ===== hdl/plc_sync2.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
module plc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("plc_sync2: WIDTH must be at least 1");
        end
    endgenerate

    // First stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // plc_sync2

// ===== hdl/plc_link_regs.sv
// Link control and link status register logic of one switch port
//
// Overview of operation
// - Entry field: 00 none, 01 L0s, 10 L1, 11 both; resets to 00.
// - Receive side may always enter L0s, whatever the entry field says.
// - Read completion boundary bit 3 always reads zero.
// - Link disable bit 4 zero on upstream; downstream setting takes link down.
// - Retrain bit 5 zero on upstream; downstream write of one starts retraining.
// - Clocking-mode bit 6: zero asynchronous, one common clock; resets zero.
// - Extended sync: 4096 fast training sets from L0s, 1024 TS1 from L1.
// - Bits 10 and 11 read zero upstream, writable downstream, reset zero.
// - Speed field 19:16: 0001 for 2.5, 0010 for 5.0; resets 0010.
// - Width field 25:20 shows trained lane count; resets to one lane.
// - Training error bit 26 set on failure, cleared on training to L0.
// - Training bit 27 reads one during training, cleared on completion.
// - Slot clock bit 28 shows clock source; reset value from strap pin.
// - Bit 29 reads one while data link is in DL_Active.
`timescale 1ns/1ns
`include "plc_cfg.svh"
module plc_link_regs #(
    parameter bit DOWNSTREAM = 1'b1,
    parameter int ADDR_W = 12,
    parameter logic [12:0] NORM_FTS = 13'h0080,
    parameter logic [12:0] NORM_TS1 = 13'h0010
) (
    input wire logic core_clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // From the training and data link logic (same clock)
    input wire logic train_start_evt,
    input wire logic train_done_evt,
    input wire logic train_fail_evt,
    input wire logic [3:0] trained_speed,
    input wire logic [5:0] trained_width,
    input wire logic dl_active_in,
    // Strap pin
    input wire logic slot_clock_strap,
    // To the training logic
    output logic l0s_entry_en,
    output logic l1_entry_en,
    output logic rx_l0s_allowed,
    output logic link_disable,
    output logic retrain_start,
    output logic common_clock,
    output logic hardware_lane_count_change_block,
    output logic bw_mgmt_int_en,
    output logic auto_bw_int_en,
    output logic [12:0] fts_count,
    output logic [12:0] ts1_count
);
    localparam logic [ADDR_W-3:0] LINK_WORD = (ADDR_W-2)'(ADDR_W'(`PLC_LINK_OFS) >> 2);

    generate
        if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
            $error("plc_link_regs: ADDR_W must be 8 to 32");
        end
    endgenerate

    // Control state
    plc_pkg::plc_active_state_power_entry_type active_state_power_entry_r;
    logic dis_r;
    logic cclk_r;
    logic esync_r;
    logic lccb_r;
    logic bwm_ie_r;
    logic abw_ie_r;
    // Status state
    logic [3:0] speed_r;
    logic [5:0] width_r;
    logic terr_r;
    logic train_r;
    logic sclk_r;
    logic dla_r;
    logic strap_s;
    logic [1:0] strap_cnt_r;
    // Bus state
    plc_pkg::plc_wr_state_type wr_state_r;
    logic aw_ok_r;
    logic w_ok_r;
    logic [ADDR_W-3:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_hit;
    logic wr_go;
    logic rd_hit;
    logic [31:0] rd_word;

    // Strap synchroniser
    plc_sync2 #(
        .WIDTH(1)
    ) u_strap_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(slot_clock_strap),
        .sync_out(strap_s)
    );

    // Address decode
    assign wr_hit = (waddr_r == LINK_WORD);
    assign rd_hit = (s_axi_araddr[ADDR_W-1:2] == LINK_WORD);
    assign wr_go = aw_ok_r && w_ok_r && (wr_state_r == plc_pkg::PLC_WR_IDLE);

    // Register read image; unlisted bits stay zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_word[`PLC_ACTIVE_STATE_POWER_ENTRY_LSB +: 2] = active_state_power_entry_r;
        rd_word[`PLC_RCB_BIT] = 1'b0;
        rd_word[`PLC_DIS_BIT] = dis_r;
        rd_word[`PLC_RETRAIN_BIT] = 1'b0;
        rd_word[`PLC_CCLK_BIT] = cclk_r;
        rd_word[`PLC_ESYNC_BIT] = esync_r;
        rd_word[`PLC_LCCB_BIT] = lccb_r;
        rd_word[`PLC_BWM_IE_BIT] = bwm_ie_r;
        rd_word[`PLC_ABW_IE_BIT] = abw_ie_r;
        rd_word[`PLC_SPEED_LSB +: 4] = speed_r;
        rd_word[`PLC_WIDTH_LSB +: 6] = width_r;
        rd_word[`PLC_TERR_BIT] = terr_r;
        rd_word[`PLC_TRAIN_BIT] = train_r;
        rd_word[`PLC_SCLK_BIT] = sclk_r;
        rd_word[`PLC_DLA_BIT] = dla_r;
    end

    // Write address channel capture
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            aw_ok_r <= 1'b0;
            waddr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_ok_r <= 1'b1;
            waddr_r <= s_axi_awaddr[ADDR_W-1:2];
        end else if (wr_go) begin
            aw_ok_r <= 1'b0;
        end else if (s_axi_awvalid && !aw_ok_r && wr_state_r == plc_pkg::PLC_WR_IDLE) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Write data channel capture
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_wready <= 1'b0;
            w_ok_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_ok_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_ok_r <= 1'b0;
        end else if (s_axi_wvalid && !w_ok_r && wr_state_r == plc_pkg::PLC_WR_IDLE) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Write response sequencing
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_state_r <= plc_pkg::PLC_WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PLC_RESP_OKAY;
        end else begin
            case (wr_state_r)
                plc_pkg::PLC_WR_IDLE: begin
                    if (wr_go) begin
                        wr_state_r <= plc_pkg::PLC_WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_hit ? `PLC_RESP_OKAY : `PLC_RESP_SLVERR;
                    end
                end
                plc_pkg::PLC_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_r <= plc_pkg::PLC_WR_DONE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                plc_pkg::PLC_WR_DONE: begin
                    wr_state_r <= plc_pkg::PLC_WR_IDLE; // Lets ready flags settle
                end
                default: begin
                    wr_state_r <= plc_pkg::PLC_WR_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // Read channel: one transfer at a time
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PLC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? rd_word : 32'h0000_0000;
            s_axi_rresp <= rd_hit ? `PLC_RESP_OKAY : `PLC_RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Byte 0 of control
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            active_state_power_entry_r <= plc_pkg::PLC_ACTIVE_STATE_POWER_ENTRY_NONE;
            dis_r <= 1'b0;
            cclk_r <= 1'b0;
            esync_r <= 1'b0;
        end else if (wr_go && wr_hit && wstrb_r[0]) begin
            active_state_power_entry_r <= plc_pkg::plc_active_state_power_entry_type'(wdata_r[`PLC_ACTIVE_STATE_POWER_ENTRY_LSB +: 2]);
            dis_r <= DOWNSTREAM && wdata_r[`PLC_DIS_BIT];
            cclk_r <= wdata_r[`PLC_CCLK_BIT];
            esync_r <= wdata_r[`PLC_ESYNC_BIT];
        end
    end

    // Byte 1 of control
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lccb_r <= 1'b0;
            bwm_ie_r <= 1'b0;
            abw_ie_r <= 1'b0;
        end else if (wr_go && wr_hit && wstrb_r[1]) begin
            lccb_r <= wdata_r[`PLC_LCCB_BIT];
            bwm_ie_r <= DOWNSTREAM && wdata_r[`PLC_BWM_IE_BIT];
            abw_ie_r <= DOWNSTREAM && wdata_r[`PLC_ABW_IE_BIT];
        end
    end

    // Retrain request pulse, never stored
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            retrain_start <= 1'b0;
        end else begin
            retrain_start <= DOWNSTREAM && wr_go && wr_hit && wstrb_r[0]
                && wdata_r[`PLC_RETRAIN_BIT];
        end
    end

    // Negotiated speed and width, taken when training completes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            speed_r <= `PLC_SPEED_RST;
            width_r <= `PLC_WIDTH_RST;
        end else if (train_done_evt) begin
            speed_r <= trained_speed;
            width_r <= trained_width;
        end
    end

    // Training error flag; a failure wins over a success
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            terr_r <= 1'b0;
        end else if (train_fail_evt) begin
            terr_r <= 1'b1;
        end else if (train_done_evt) begin
            terr_r <= 1'b0;
        end
    end

    // Training in progress; a new start wins over an end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            train_r <= 1'b0;
        end else if (train_start_evt || retrain_start) begin
            train_r <= 1'b1;
        end else if (train_done_evt || train_fail_evt) begin
            train_r <= 1'b0;
        end
    end

    // Slot clock flag loaded once from the settled strap
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strap_cnt_r <= 2'h0;
            sclk_r <= 1'b0;
        end else if (strap_cnt_r != `PLC_STRAP_WAIT) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == `PLC_STRAP_WAIT - 2'h1) begin
                sclk_r <= strap_s;
            end
        end
    end

    // Data link active mirror
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dla_r <= 1'b0;
        end else begin
            dla_r <= dl_active_in;
        end
    end

    // Controls handed to the training logic
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            l0s_entry_en <= 1'b0;
            l1_entry_en <= 1'b0;
            rx_l0s_allowed <= 1'b1;
            link_disable <= 1'b0;
            common_clock <= 1'b0;
            hardware_lane_count_change_block <= 1'b0;
            bw_mgmt_int_en <= 1'b0;
            auto_bw_int_en <= 1'b0;
            fts_count <= NORM_FTS;
            ts1_count <= NORM_TS1;
        end else begin
            l0s_entry_en <= active_state_power_entry_r[0];
            l1_entry_en <= active_state_power_entry_r[1];
            rx_l0s_allowed <= 1'b1;
            link_disable <= dis_r;
            common_clock <= cclk_r;
            hardware_lane_count_change_block <= lccb_r;
            bw_mgmt_int_en <= bwm_ie_r;
            auto_bw_int_en <= abw_ie_r;
            fts_count <= esync_r ? `PLC_ESYNC_FTS : NORM_FTS;
            ts1_count <= esync_r ? `PLC_ESYNC_TS1 : NORM_TS1;
        end
    end
endmodule // plc_link_regs

// ===== test/plc_sva.sv
// Port checks for the link register block
`timescale 1ns/1ns
module plc_sva #(
    parameter bit DOWNSTREAM = 1'b1,
    parameter logic [12:0] NORM_FTS = 13'h0080,
    parameter logic [12:0] NORM_TS1 = 13'h0010
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_l0s_allowed,
    input wire logic link_disable,
    input wire logic retrain_start,
    input wire logic [12:0] fts_count,
    input wire logic [12:0] ts1_count
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Power, count, disable and retrain outputs
    a_rx_l0s_on: assert property (rx_l0s_allowed)
        else $error("rx L0s permission dropped");
    a_esync_counts: assert property ((fts_count == 13'h1000 && ts1_count == 13'h0400)
        || (fts_count == NORM_FTS && ts1_count == NORM_TS1)) else $error("bad set counts");
    a_upstream_fixed: assert property (DOWNSTREAM || (!link_disable && !retrain_start))
        else $error("upstream control not fixed");
    a_retrain_single: assert property (retrain_start |=> !retrain_start)
        else $error("retrain pulse too long");
    // Read data contents
    a_rsvd_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hc000_f12c) == 32'h0)
        else $error("reserved bits set");
    a_slverr_data: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read with data");
    // Bus handshakes
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held");
endmodule // plc_sva

bind plc_link_regs plc_sva #(.DOWNSTREAM(DOWNSTREAM), .NORM_FTS(NORM_FTS), .NORM_TS1(NORM_TS1))
    u_plc_sva (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rx_l0s_allowed(rx_l0s_allowed), .link_disable(link_disable),
    .retrain_start(retrain_start), .fts_count(fts_count), .ts1_count(ts1_count));

// ===== test/plc_train_model.sv
// Training-side partner: start, then done or fail after a chosen delay
`timescale 1ns/1ns
module plc_train_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic ok,
    input wire logic [3:0] lat,
    input wire logic [9:0] sw,
    output logic start_evt,
    output logic done_evt,
    output logic fail_evt,
    output logic [9:0] sw_out,
    output logic dl_active
);
    logic [3:0] cnt_r;
    // Start pulse, count down, then finish
    always_ff @(posedge core_clk) begin
        start_evt <= go;
        done_evt <= 1'b0;
        fail_evt <= 1'b0;
        if (!rst_n) cnt_r <= 4'h0;
        else if (go) cnt_r <= lat;
        else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
        if (rst_n && cnt_r == 4'h1) begin
            done_evt <= ok;
            fail_evt <= !ok;
        end
    end
    // Width and speed only valid with done
    assign sw_out = done_evt ? sw : ~sw;
    // Link up after a good finish
    always_ff @(posedge core_clk) begin
        if (!rst_n || go) dl_active <= 1'b0;
        else if (done_evt) dl_active <= 1'b1;
    end
endmodule // plc_train_model

// ===== test/test_pcie_port_link_control_status.sv
// Testbench for the link register block
`timescale 1ns/1ns
module test_pcie_port_link_control_status;
    logic core_clk, rst_n, awv, wv, bready, arv, rready, strap, go, ok;
    logic awr, wr_r, bv, arr, rv, l0s, l1, rxl0s, ldis, rtr, cclk, lccb, bwie, abwie;
    logic st_e, dn_e, fl_e, dla;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, lat;
    logic [1:0] bresp, rresp;
    logic [9:0] sw, swo;
    logic [12:0] fts, ts1;
    logic [15:0] ctl, st;
    logic up_ldis, up_rtr, up_bwie, up_abwie;
    logic [31:0] up_rdata;
    logic [1:0] up_rresp;
    logic [33:0] re;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int errors, n_compared, n_rt, exp_rt;

    plc_link_regs #(.DOWNSTREAM(1'b1), .ADDR_W(12), .NORM_FTS(13'h0080), .NORM_TS1(13'h0010))
    u_plc_link_regs (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
        .train_start_evt(st_e), .train_done_evt(dn_e), .train_fail_evt(fl_e),
        .trained_speed(swo[3:0]), .trained_width(swo[9:4]), .dl_active_in(dla),
        .slot_clock_strap(strap), .l0s_entry_en(l0s), .l1_entry_en(l1), .rx_l0s_allowed(rxl0s),
        .link_disable(ldis), .retrain_start(rtr), .common_clock(cclk),
        .hardware_lane_count_change_block(lccb), .bw_mgmt_int_en(bwie),
        .auto_bw_int_en(abwie), .fts_count(fts), .ts1_count(ts1));

    plc_train_model u_plc_train_model (.core_clk(core_clk), .rst_n(rst_n), .go(go), .ok(ok),
        .lat(lat), .sw(sw), .start_evt(st_e), .done_evt(dn_e), .fail_evt(fl_e), .sw_out(swo),
        .dl_active(dla));

    // Upstream port twin on the same bus, for the fixed-zero bits
    plc_link_regs #(.DOWNSTREAM(1'b0), .ADDR_W(12), .NORM_FTS(13'h0080), .NORM_TS1(13'h0010))
    u_plc_link_regs_up (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wv), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(),
        .s_axi_rdata(up_rdata), .s_axi_rresp(up_rresp), .s_axi_rvalid(), .s_axi_rready(rready),
        .train_start_evt(st_e), .train_done_evt(dn_e), .train_fail_evt(fl_e),
        .trained_speed(swo[3:0]), .trained_width(swo[9:4]), .dl_active_in(dla),
        .slot_clock_strap(strap), .l0s_entry_en(), .l1_entry_en(), .rx_l0s_allowed(),
        .link_disable(up_ldis), .retrain_start(up_rtr), .common_clock(),
        .hardware_lane_count_change_block(), .bw_mgmt_int_en(up_bwie),
        .auto_bw_int_en(up_abwie), .fts_count(), .ts1_count());

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic final_report();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Answer monitor, oldest note first
    always @(posedge core_clk) begin
        if (rv && rready) begin
            re = rq.pop_front();
            cmp("read", re, {rresp, rdata});
            cmp("up read", re & 34'h3_f7ff_f3cf,
                {up_rresp, up_rdata} & 34'h3_f7ff_ffff);
        end
        if (bv && bready) cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
        if (rtr) n_rt++;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge core_clk);
        bq.push_back(a == 12'h0d0 ? 2'h0 : 2'h2);
        awaddr <= a; wdata <= d; wstrb <= s; awv <= 1'b1; wv <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (!bv);
        bready <= 1'b1;
        @(posedge core_clk);
        bready <= 1'b0;
        if (a == 12'h0d0 && s[0]) begin
            ctl[7:0] = d[7:0] & 8'hd3;
            if (d[5]) exp_rt++;
            if (d[5]) st[11] = 1'b1;
        end
        if (a == 12'h0d0 && s[1]) ctl[15:8] = d[15:8] & 8'h0e;
    endtask

    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        @(posedge core_clk);
        rq.push_back(e);
        araddr <= a; arv <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rready <= 1'b1;
        @(posedge core_clk);
        rready <= 1'b0;
    endtask

    // Control outputs against the expected control half
    task automatic chk_out();
        @(negedge core_clk);
        cmp("ports", {ctl[0], ctl[1], 1'b1, ctl[4], ctl[6], ctl[9], ctl[10], ctl[11],
            ctl[7] ? 13'h1000 : 13'h0080, ctl[7] ? 13'h0400 : 13'h0010},
            {l0s, l1, rxl0s, ldis, cclk, lccb, bwie, abwie, fts, ts1});
        cmp("up ports", 34'h0, {30'h0, up_ldis, up_rtr, up_bwie, up_abwie});
    endtask

    task automatic train(input logic good, input logic [3:0] l);
        @(posedge core_clk);
        go <= 1'b1; ok <= good; lat <= l;
        sw <= {6'($urandom % 16 + 1), ($urandom % 2) ? 4'h1 : 4'h2};
        @(posedge core_clk);
        go <= 1'b0;
        st[11] = 1'b1;
        st[13] = 1'b0;
        if (l == 4'hf) rd(12'h0d0, {2'h0, st, ctl});
        while (!(dn_e || fl_e)) @(posedge core_clk);
        st[11] = 1'b0;
        st[10] = !good;
        if (good) st[13] = 1'b1;
        if (good) st[9:0] = sw;
        rd(12'h0d0, {2'h0, st, ctl});
    endtask

    // Watchdog
    initial begin
        repeat (5000) @(posedge core_clk);
        errors++;
        final_report();
    end

    initial begin
        {rst_n, awv, wv, bready, arv, rready, go, ok} = '0;
        {awaddr, araddr, wdata, wstrb, lat, sw} = '0;
        strap = 1'b1;
        void'($urandom(32'h9a38));
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        ctl = 16'h0;
        st = 16'h1012;
        rd(12'h0d0, {2'h0, st, ctl});
        for (int i = 0; i < 4; i++) begin
            wr(12'h0d0, 32'(i), 4'h1);
            chk_out();
            rd(12'h0d0, {2'h0, st, ctl});
        end
        for (int i = 0; i < 7; i++) begin
            wr(12'h0d0, i == 6 ? 32'hffff_ffff : $urandom,
                i == 6 ? 4'hf : 4'($urandom % 4));
            chk_out();
            rd(12'h0d0, {2'h0, st, ctl});
        end
        wr(12'h0d4, 32'h0, 4'hf);
        rd(12'h0d4, {2'h2, 32'h0});
        rd(12'h0d0, {2'h0, st, ctl});
        train(1'b1, 4'hf);
        train(1'b0, 4'($urandom % 8 + 2));
        train(1'b1, 4'($urandom % 8 + 2));
        // Second reset with the strap low: all fields back to their reset image
        @(posedge core_clk);
        rst_n <= 1'b0;
        strap <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        ctl = 16'h0;
        st = 16'h0012;
        rd(12'h0d0, {2'h0, st, ctl});
        chk_out();
        wr(12'h0d0, 32'h0, 4'h3);
        chk_out();
        repeat (3) @(posedge core_clk);
        cmp("retrain", 34'(exp_rt), 34'(n_rt));
        final_report();
    end
endmodule // test_pcie_port_link_control_status
